// File: ugcr_cfg.svh
// constants of the general-command register set
`ifndef UGCR_CFG_SVH
`define UGCR_CFG_SVH

// command codes
`define UGCR_CMD_WR_SCRATCH   8'hb2
`define UGCR_CMD_RD_SCRATCH   8'hb3
`define UGCR_CMD_RD_FRAME     8'hb4
`define UGCR_CMD_RD_IDENT     8'hb5
`define UGCR_CMD_RD_IRQ       8'hc0

// reset values
`define UGCR_SCRATCH_RST      15'h0000
`define UGCR_FRAME_RST        11'h000
`define UGCR_IRQ_RST          24'h000000

// field widths and positions
`define UGCR_SCRATCH_W        15
`define UGCR_FRAME_W          11
`define UGCR_IRQ_W            24
`define UGCR_EP_W             16
`define UGCR_IRQ_EP_LSB       8
`define UGCR_IRQ_BUS_STATE    7
`define UGCR_IRQ_SHORT_EOT    6
`define UGCR_IRQ_PSEUDO_FRAME_TICK_FLAG         5
`define UGCR_IRQ_SOF          4
`define UGCR_IRQ_EOT          3
`define UGCR_IRQ_SUSPEND      2
`define UGCR_IRQ_RESUME       1
`define UGCR_IRQ_BUS_RESET    0
// event bits cleared by reading the interrupt source register
`define UGCR_IRQ_RD_CLR_MASK  24'h00007f

// timing
`define UGCR_CLK_HZ           10000000
`define UGCR_PSEUDO_FRAME_TICK_FLAG_PERIOD_US   1000
`define UGCR_PSEUDO_FRAME_TICK_FLAG_MISS_MAX    3
`define UGCR_PSEUDO_FRAME_TICK_FLAG_CNT_W       16

// identity, arbitrary neutral values
`define UGCR_PART_CODE        8'h5a
`define UGCR_SILICON_VERSION  8'h10

`endif

// File: ugcr_pkg.sv
// types of the general-command register set
package ugcr_pkg;

	typedef enum logic [2:0] {
		UGCR_IDLE,
		UGCR_WR_SCRATCH,
		UGCR_RD_SCRATCH,
		UGCR_RD_FRAME,
		UGCR_RD_IDENT,
		UGCR_RD_IRQ
	} ugcr_phase_t;

endpackage

// File: ugcr_pseudo_frame_tick_flag_timer.sv
// pseudo frame tick and missed-frame suspend detector
`timescale 1ns/1ps
`include "ugcr_cfg.svh"

module ugcr_pseudo_frame_tick_flag_timer #(
	parameter int PERIOD_CYCLES = 10000
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic sof_good,
	input  wire logic bus_reset,
	output logic      tick_reg,
	output logic      miss_suspend_reg
);

	localparam logic [`UGCR_PSEUDO_FRAME_TICK_FLAG_CNT_W-1:0] LAST =
		(`UGCR_PSEUDO_FRAME_TICK_FLAG_CNT_W)'(PERIOD_CYCLES - 1);

	logic [`UGCR_PSEUDO_FRAME_TICK_FLAG_CNT_W-1:0] count_reg;
	logic [1:0]                  missed_reg;
	logic                        armed_reg;
	logic                        expire;

	// no ticks before the first frame: nothing to keep in step with yet
	assign expire = armed_reg && !miss_suspend_reg && (count_reg == LAST);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
		end else if (sof_good || bus_reset || expire) begin
			count_reg <= '0;
		end else if (armed_reg) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed_reg <= 1'b0;
		end else if (sof_good) begin
			armed_reg <= 1'b1;
		end else if (bus_reset) begin
			armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= expire && !sof_good;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			missed_reg       <= 2'd0;
			miss_suspend_reg <= 1'b0;
		end else if (sof_good || bus_reset) begin
			missed_reg       <= 2'd0;
			miss_suspend_reg <= 1'b0;
		end else if (expire) begin
			missed_reg <= missed_reg + 2'd1;
			if (missed_reg == 2'(`UGCR_PSEUDO_FRAME_TICK_FLAG_MISS_MAX - 1)) begin
				miss_suspend_reg <= 1'b1;
			end
		end
	end

endmodule

// File: ugcr_regs.sv
// general-command register set behind the parallel command/data port
`timescale 1ns/1ps
`include "ugcr_cfg.svh"

// Overview of operation
// - scratch word written b2, read b3, resets zero
// - b4 returns frame of last good SOF
// - frame read one or two bytes, low first
// - frame eleven bits, bits 15-11 read zero
// - frame value undefined after bus reset
// - byte bus: command, then low, high bytes
// - word bus: command low lanes, one word, two for c0
// - b5 returns part code and version bytes
// - c0 returns four irq bytes, all read
// - irq bits 23-8 endpoint flags, 31-24 zero
// - irq bit 7 shows live suspend state
// - irq bit 6 set on short-packet end
// - bit 5 pseudo tick, three misses suspend
// - bit 4 on SOF, bit 3 DMA zero
// - bit 2 suspend entry, 1 resume, 0 reset
// - irq read clears events; endpoints by status read
module ugcr_regs #(
	parameter int PSEUDO_FRAME_TICK_FLAG_CYCLES =
		`UGCR_CLK_HZ / 1000000 * `UGCR_PSEUDO_FRAME_TICK_FLAG_PERIOD_US,
	parameter logic [7:0] PART_CODE = `UGCR_PART_CODE,
	parameter logic [7:0] SILICON_VERSION = `UGCR_SILICON_VERSION
) (
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     bus_is_16bit,
	input  wire logic                     cmd_data_select,
	input  wire logic                     wr_stb,
	input  wire logic                     rd_stb,
	input  wire logic [15:0]              data_in,
	output logic [15:0]                   data_out_reg,
	output logic                          data_oe_reg,
	input  wire logic                     sof_good,
	input  wire logic [`UGCR_FRAME_W-1:0] sof_frame,
	input  wire logic                     bus_reset_det,
	input  wire logic                     resume_det,
	input  wire logic                     bus_suspended,
	input  wire logic                     short_pkt_eot,
	input  wire logic                     dma_count_zero,
	input  wire logic [`UGCR_EP_W-1:0]    ep_event,
	input  wire logic [`UGCR_EP_W-1:0]    ep_status_read,
	output logic                          suspend_state_reg
);

	ugcr_pkg::ugcr_phase_t        phase_reg;
	logic [1:0]                   index_reg;
	logic [`UGCR_SCRATCH_W-1:0]   scratch_store_reg;
	logic [`UGCR_FRAME_W-1:0]     frame_number_reg;
	logic [`UGCR_IRQ_W-1:0]       irq_sources_reg;
	logic [31:0]                  irq_snap_reg;
	logic [`UGCR_IRQ_W-1:0]       irq_set;
	logic [`UGCR_IRQ_W-1:0]       irq_clr;
	logic                         cmd_wr;
	logic                         data_wr;
	logic                         data_rd;
	logic                         irq_read;
	logic                         pseudo_frame_tick_flag_tick;
	logic                         miss_suspend;
	logic                         suspend_next;
	logic [31:0]                  rd_word;

	////////////////////////////////////////////////////////////////////////
	// pick one byte or word of a read value by transfer index
	function automatic logic [15:0] lane(input logic [31:0] w,
		input logic [1:0] idx, input logic wide);
		logic [15:0] r;
		r = 16'h0000;
		if (wide) begin
			r = idx[0] ? w[31:16] : w[15:0];
		end else begin
			case (idx)
				2'd0: r = {8'h00, w[7:0]};
				2'd1: r = {8'h00, w[15:8]};
				2'd2: r = {8'h00, w[23:16]};
				default: r = {8'h00, w[31:24]};
			endcase
		end
		return r;
	endfunction

	assign cmd_wr  = wr_stb && cmd_data_select;
	assign data_wr = wr_stb && !cmd_data_select;
	assign data_rd = rd_stb && !cmd_data_select;
	// only low lanes carry the command code
	assign irq_read = cmd_wr && (data_in[7:0] == `UGCR_CMD_RD_IRQ);

	////////////////////////////////////////////////////////////////////////
	// command phase and transfer index
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= ugcr_pkg::UGCR_IDLE;
		end else if (cmd_wr) begin
			case (data_in[7:0])
				`UGCR_CMD_WR_SCRATCH: phase_reg <= ugcr_pkg::UGCR_WR_SCRATCH;
				`UGCR_CMD_RD_SCRATCH: phase_reg <= ugcr_pkg::UGCR_RD_SCRATCH;
				`UGCR_CMD_RD_FRAME:   phase_reg <= ugcr_pkg::UGCR_RD_FRAME;
				`UGCR_CMD_RD_IDENT:   phase_reg <= ugcr_pkg::UGCR_RD_IDENT;
				`UGCR_CMD_RD_IRQ:     phase_reg <= ugcr_pkg::UGCR_RD_IRQ;
				default:              phase_reg <= ugcr_pkg::UGCR_IDLE;
			endcase
		end
	end

	// index saturates: extra data phases read zero, writes are dropped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			index_reg <= 2'd0;
		end else if (cmd_wr) begin
			index_reg <= 2'd0;
		end else if ((data_wr || data_rd) && index_reg != 2'd3) begin
			index_reg <= index_reg + 2'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scratch store; bit 15 is not kept, firmware writes it zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scratch_store_reg <= `UGCR_SCRATCH_RST;
		end else if (data_wr && phase_reg == ugcr_pkg::UGCR_WR_SCRATCH) begin
			if (bus_is_16bit) begin
				if (index_reg == 2'd0) begin
					scratch_store_reg <= data_in[14:0];
				end
			end else if (index_reg == 2'd0) begin
				scratch_store_reg[7:0] <= data_in[7:0];
			end else if (index_reg == 2'd1) begin
				scratch_store_reg[14:8] <= data_in[6:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame number of last good SOF; bus reset leaves it stale
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_number_reg <= `UGCR_FRAME_RST;
		end else if (sof_good) begin
			frame_number_reg <= sof_frame;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pseudo frame tick and missed-frame suspend
	ugcr_pseudo_frame_tick_flag_timer #(
		.PERIOD_CYCLES (PSEUDO_FRAME_TICK_FLAG_CYCLES)
	) u_pseudo_frame_tick_flag (
		.clk              (clk),
		.resetn           (resetn),
		.sof_good         (sof_good),
		.bus_reset        (bus_reset_det),
		.tick_reg         (pseudo_frame_tick_flag_tick),
		.miss_suspend_reg (miss_suspend)
	);

	assign suspend_next = bus_suspended || miss_suspend;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			suspend_state_reg <= 1'b0;
		end else begin
			suspend_state_reg <= suspend_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt sources; a set in the clearing cycle wins
	always_comb begin
		irq_set = '0;
		irq_set[`UGCR_IRQ_W-1:`UGCR_IRQ_EP_LSB] = ep_event;
		irq_set[`UGCR_IRQ_SHORT_EOT] = short_pkt_eot;
		irq_set[`UGCR_IRQ_PSEUDO_FRAME_TICK_FLAG]      = pseudo_frame_tick_flag_tick;
		irq_set[`UGCR_IRQ_SOF]       = sof_good;
		irq_set[`UGCR_IRQ_EOT]       = dma_count_zero;
		irq_set[`UGCR_IRQ_SUSPEND]   = suspend_next && !suspend_state_reg;
		irq_set[`UGCR_IRQ_RESUME]    = resume_det;
		irq_set[`UGCR_IRQ_BUS_RESET] = bus_reset_det;
	end

	always_comb begin
		irq_clr = '0;
		irq_clr[`UGCR_IRQ_W-1:`UGCR_IRQ_EP_LSB] = ep_status_read;
		if (irq_read) begin
			irq_clr = irq_clr | `UGCR_IRQ_RD_CLR_MASK;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_sources_reg <= `UGCR_IRQ_RST;
		end else begin
			irq_sources_reg <= (irq_sources_reg & ~irq_clr) | irq_set;
		end
	end

	// snapshot at the command so all four bytes are coherent
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_snap_reg <= 32'h00000000;
		end else if (irq_read) begin
			irq_snap_reg <= {8'h00, irq_sources_reg[`UGCR_IRQ_W-1:8],
				suspend_state_reg, irq_sources_reg[6:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data path
	always_comb begin
		case (phase_reg)
			ugcr_pkg::UGCR_RD_SCRATCH:
				rd_word = {16'h0000, 1'b0, scratch_store_reg};
			ugcr_pkg::UGCR_RD_FRAME:
				rd_word = {21'h000000, frame_number_reg};
			ugcr_pkg::UGCR_RD_IDENT:
				rd_word = {16'h0000, PART_CODE, SILICON_VERSION};
			ugcr_pkg::UGCR_RD_IRQ:
				rd_word = irq_snap_reg;
			default:
				rd_word = 32'h00000000;
		endcase
	end

	// low byte first, extra phases give zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_out_reg <= 16'h0000;
		end else if (data_rd) begin
			if (bus_is_16bit && index_reg > 2'd1) begin
				data_out_reg <= 16'h0000;
			end else begin
				data_out_reg <= lane(rd_word, index_reg, bus_is_16bit);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_oe_reg <= 1'b0;
		end else begin
			data_oe_reg <= data_rd;
		end
	end

endmodule

// File: ugcr_mcu_model.sv
// microcontroller model driving the command/data port
`timescale 1ns/1ps
module ugcr_mcu_model (
	input  wire logic        clk,
	input  wire logic [15:0] rd_data,
	output logic             sel,
	output logic             wr,
	output logic             rd,
	output logic      [15:0] wdata
);
	initial begin
		sel = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 16'h0000;
	end
	// command on low lanes with select high, data with it low
	task automatic put(input logic s, input logic [15:0] d);
		@(posedge clk);
		sel <= s;
		wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// one unit per strobe, low unit first
	task automatic get(output logic [15:0] d);
		@(posedge clk);
		sel <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rd_data;
	endtask
endmodule

// File: ugcr_regs_asserts.sv
// port checker for the general-command register set
`timescale 1ns/1ps
`include "ugcr_cfg.svh"
module ugcr_regs_asserts #(
	parameter logic [7:0] PART_CODE = `UGCR_PART_CODE
) (
	input wire logic                     clk,
	input wire logic                     resetn,
	input wire logic                     bus_is_16bit,
	input wire logic                     cmd_data_select,
	input wire logic                     wr_stb,
	input wire logic                     rd_stb,
	input wire logic [15:0]              data_in,
	input wire logic [15:0]              data_out_reg,
	input wire logic                     data_oe_reg,
	input wire logic                     sof_good,
	input wire logic [`UGCR_FRAME_W-1:0] sof_frame,
	input wire logic                     bus_suspended,
	input wire logic                     suspend_state_reg
);
	logic [7:0]  cmd_r;
	logic [1:0]  idx_r;
	logic [1:0]  oidx_r;
	logic [10:0] frame_r;
	wire rd_req = rd_stb && !cmd_data_select;
	wire ans = data_oe_reg;
	wire w16 = bus_is_16bit;
	wire is_frm = cmd_r == `UGCR_CMD_RD_FRAME;
	wire is_id = cmd_r == `UGCR_CMD_RD_IDENT;
	wire is_irq = cmd_r == `UGCR_CMD_RD_IRQ;
	wire is_scr = cmd_r == `UGCR_CMD_RD_SCRATCH;
	// index of the unit now shown, not of the next one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_r <= 8'h00;
			idx_r <= 2'h0;
			oidx_r <= 2'h0;
		end else if (wr_stb && cmd_data_select) begin
			cmd_r <= data_in[7:0];
			idx_r <= 2'h0;
		end else if (rd_req) begin
			oidx_r <= idx_r;
			idx_r <= idx_r + 2'h1;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			frame_r <= 11'h000;
		else if (sof_good)
			frame_r <= sof_frame;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	read_answer_a: assert property (rd_req |=> ans)
		else $error("read strobe got no answer");
	answer_cause_a: assert property (ans |-> $past(rd_req))
		else $error("answer without read strobe");
	byte_lane_a: assert property (ans && !w16 |-> !data_out_reg[15:8])
		else $error("byte mode upper lanes not zero");
	frame_word_a: assert property (ans && w16 && is_frm && oidx_r == 2'h0
		|-> data_out_reg == {5'h00, frame_r}) else $error("frame word wrong");
	frame_low_a: assert property (ans && !w16 && is_frm && oidx_r == 2'h0
		|-> data_out_reg[7:0] == frame_r[7:0]) else $error("frame low byte");
	frame_top_a: assert property (ans && is_frm |-> !data_out_reg[15:11])
		else $error("reserved frame bits set");
	ident_code_a: assert property (ans && w16 && is_id && oidx_r == 2'h0
		|-> data_out_reg[15:8] == PART_CODE) else $error("part code wrong");
	irq_top_a: assert property (ans && !w16 && is_irq && oidx_r == 2'h3
		|-> data_out_reg == 16'h0000) else $error("reserved irq byte set");
	scratch_top_a: assert property (ans && w16 && is_scr
		|-> !data_out_reg[15]) else $error("scratch bit 15 set");
	suspend_live_a: assert property (bus_suspended |=> suspend_state_reg)
		else $error("suspend state not following bus");
	cover property (ans && !w16 && is_irq && oidx_r == 2'h3);
	cover property (ans && w16 && is_frm);
	cover property ($rose(suspend_state_reg));
endmodule
bind ugcr_regs ugcr_regs_asserts #(.PART_CODE(PART_CODE)) chk_u (.*);

// File: ugcr_regs_test.sv
// self-checking bench for the general-command register set
`timescale 1ns/1ps
module ugcr_regs_test;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        wide = 1'b1;
	logic        susp = 1'b0;
	logic [4:0]  ev = 5'h00;
	logic [15:0] ep_ev = 16'h0000;
	logic [15:0] ep_rd = 16'h0000;
	logic [10:0] frm = 11'h000;
	logic        sel, wr, rd, oe, sst;
	logic [15:0] wdata, rdata, v;
	int          fails = 0;
	int          samples_checked = 0;
	always #50 clk = ~clk;
	// short pseudo frame period keeps the miss run brief
	ugcr_regs #(.PSEUDO_FRAME_TICK_FLAG_CYCLES(20)) dut_u (.clk(clk), .resetn(resetn),
		.bus_is_16bit(wide), .cmd_data_select(sel), .wr_stb(wr),
		.rd_stb(rd), .data_in(wdata), .data_out_reg(rdata),
		.data_oe_reg(oe), .sof_good(ev[4]), .sof_frame(frm),
		.bus_reset_det(ev[0]), .resume_det(ev[1]), .bus_suspended(susp),
		.short_pkt_eot(ev[3]), .dma_count_zero(ev[2]), .ep_event(ep_ev),
		.ep_status_read(ep_rd), .suspend_state_reg(sst));
	ugcr_mcu_model mcu_u (.clk(clk), .rd_data(rdata), .sel(sel), .wr(wr),
		.rd(rd), .wdata(wdata));
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rdc(input logic [15:0] exp);
		mcu_u.get(v);
		chk(v, exp);
	endtask
	task automatic cmd(input logic [7:0] c);
		mcu_u.put(1'b1, {8'h00, c});
	endtask
	task automatic pulse(input logic [4:0] e, input logic [15:0] p);
		@(posedge clk);
		ev <= e;
		ep_ev <= p;
		@(posedge clk);
		ev <= 5'h00;
		ep_ev <= 16'h0000;
	endtask
	// byte-wide read of all four source bytes, low byte first
	task automatic irq8(input logic [31:0] e);
		cmd(8'hc0);
		for (int i = 0; i < 4; i++)
			rdc({8'h00, e[8*i +: 8]});
	endtask
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		cmd(8'hb5);
		rdc(16'h5a10);
		cmd(8'hb3);
		rdc(16'h0000);
		cmd(8'hb2);
		mcu_u.put(1'b0, 16'h7abc);
		cmd(8'hb3);
		rdc(16'h7abc);
		@(posedge clk);
		wide <= 1'b0;
		cmd(8'hb2);
		mcu_u.put(1'b0, 16'h0034);
		mcu_u.put(1'b0, 16'h0012);
		cmd(8'hb3);
		rdc(16'h0034);
		rdc(16'h0012);
		cmd(8'h77);
		rdc(16'h0000);
		pulse(5'h0f, 16'h8001);
		irq8(32'h0080014b);
		irq8(32'h00800100);
		@(posedge clk);
		ep_rd <= 16'h8001;
		@(posedge clk);
		ep_rd <= 16'h0000;
		irq8(32'h00000000);
		@(posedge clk);
		frm <= 11'h5a3;
		pulse(5'h10, 16'h0000);
		irq8(32'h00000010);
		cmd(8'hb4);
		rdc(16'h00a3);
		rdc(16'h0005);
		cmd(8'hb4);
		rdc(16'h00a3);
		@(posedge clk);
		wide <= 1'b1;
		mcu_u.put(1'b1, 16'hffb4);
		rdc(16'h05a3);
		for (int i = 0; i < 100 && sst !== 1'b1; i++)
			@(posedge clk);
		@(negedge clk);
		chk({15'h0000, sst}, 16'h0001);
		if (sst !== 1'b1)
			end_of_test();
		cmd(8'hc0);
		rdc(16'h00a4);
		rdc(16'h0000);
		cmd(8'hc0);
		rdc(16'h0080);
		@(posedge clk);
		susp <= 1'b1;
		pulse(5'h10, 16'h0000);
		@(posedge clk);
		susp <= 1'b0;
		pulse(5'h10, 16'h0000);
		cmd(8'hc0);
		rdc(16'h0010);
		rdc(16'h0000);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		cmd(8'hb3);
		rdc(16'h0000);
		end_of_test();
	end
endmodule
